// [pmc_pkg.sv]
// Package for the power mode controller: register map, fields and state types.
package pmc_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] PLL_CTRL_OFF   = 8'h00;
  localparam logic [7:0] REG_CTRL_OFF   = 8'h04;
  localparam logic [7:0] MODE_CMD_OFF   = 8'h08;
  localparam logic [7:0] STATUS_OFF     = 8'h0c;
  localparam logic [7:0] ADDR_MASK      = 8'hfc;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int PLL_BYPASS_BIT  = 0;
  localparam int PLL_ENABLE_BIT  = 1;
  localparam int SW_LO           = 0;
  localparam int SW_HI           = 1;
  localparam int VSEL_LO         = 4;
  localparam int VSEL_HI         = 7;
  localparam int VREG_BYP_BIT    = 8;
  localparam int CMD_LO          = 0;
  localparam int CMD_HI          = 1;

  // ----------------------------------------------------------------
  // Values
  // ----------------------------------------------------------------
  localparam logic [1:0]  SW_OFF        = 2'h0;
  localparam logic [1:0]  SW_RESET      = 2'h3;
  localparam logic [3:0]  VSEL_RESET    = 4'h8;
  localparam int          VSTEP_MV      = 50;
  localparam logic [1:0]  CMD_FULL_ON   = 2'h0;
  localparam logic [1:0]  CMD_ACTIVE    = 2'h1;
  localparam logic [1:0]  CMD_SLEEP     = 2'h2;
  localparam logic [1:0]  CMD_DEEP      = 2'h3;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef enum logic [2:0] {
    PMC_FULL_ON,
    PMC_ACTIVE,
    PMC_SLEEP,
    PMC_DEEP_SLEEP,
    PMC_HIBERNATE
  } pmc_mode_t;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } pmc_axi_out_t;

  typedef struct packed {
    logic        core_clk_en;
    logic        sys_clk_en;
    logic        pll_en;
    logic        pll_bypass;
    logic        regulator_on;
    logic        regulator_bypass;
    logic [3:0]  vsel;
    logic        dma_l1_allow;
    logic        async_access_allow;
    logic        pins_hiz;
    logic        boot_start;
  } pmc_power_out_t;

  typedef struct packed {
    pmc_mode_t      mode;
    logic           pll_enable;
    logic           pll_bypass;
    logic [1:0]     sw_field;
    logic [3:0]     vsel;
    logic           vreg_bypass;
    logic           aw_seen;
    logic [7:0]     aw_addr;
    logic           w_seen;
    logic [31:0]    w_data;
    logic [3:0]     w_strb;
    logic           refused;
    logic           rtc_s1;
    logic           rtc_s2;
    logic           wake_s1;
    logic           wake_s2;
    pmc_axi_out_t   axi;
    pmc_power_out_t pwr;
  } pmc_state_t;

endpackage : pmc_pkg

// [pmc_power_mode_controller.sv]
// Power mode controller: mode sequencing, clock gating, regulator control, AXI4-Lite slave.
// Notes on behaviour
// - After reset enter full-on with PLL enabled and not bypassed.
// - Active keeps PLL enabled but bypassed; core and system clocks at input rate.
// - Active still permits DMA into level-one memory.
// - PLL may be disabled in active; moves to full-on or sleep refused until re-enabled.
// - Sleep stops only the core clock; PLL and system clock keep running.
// - Wakeup from sleep goes full-on if bypass off, active if bypass on.
// - Sleep blocks system DMA into level-one memory.
// - Deep sleep stops both clocks; only reset or RTC interrupt exits.
// - From deep sleep RTC goes to active, reset goes to full-on.
// - Deep sleep denies asynchronous peripherals access to internal or external resources.
// - Writing 00 to regulator switch field enters hibernate; regulator off, clocks stopped. Taken only in full-on or active; ignored in sleep and deep sleep.
// - Hibernate places external pins in high impedance.
// - RTC wakeup or reset reactivates regulator from hibernate and starts boot.
// - Regulator control register sets logic voltage in 50 mV steps.
// - Regulator may be disabled and bypassed by software choice.
module pmc_power_mode_controller (
  // Clock and reset
  input  wire logic                    aclk,
  input  wire logic                    aresetn,
  // AXI4-Lite write address and data
  input  wire logic                    s_axi_awvalid,
  output      logic                    s_axi_awready,
  input  wire logic [7:0]              s_axi_awaddr,
  input  wire logic                    s_axi_wvalid,
  output      logic                    s_axi_wready,
  input  wire logic [31:0]             s_axi_wdata,
  input  wire logic [3:0]              s_axi_wstrb,
  // AXI4-Lite write response
  output      logic                    s_axi_bvalid,
  input  wire logic                    s_axi_bready,
  output      logic [1:0]              s_axi_bresp,
  // AXI4-Lite read
  input  wire logic                    s_axi_arvalid,
  output      logic                    s_axi_arready,
  input  wire logic [7:0]              s_axi_araddr,
  output      logic                    s_axi_rvalid,
  input  wire logic                    s_axi_rready,
  output      logic [31:0]             s_axi_rdata,
  output      logic [1:0]              s_axi_rresp,
  // Wakeup sources
  input  wire logic                    rtc_wakeup,
  input  wire logic                    wakeup_event,
  // Power and clock controls
  output      pmc_pkg::pmc_power_out_t pwr
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] pmc_merge(input logic [31:0] old_v, input logic [31:0] new_v,
                                            input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction : pmc_merge

  function automatic logic [7:0] pmc_word_addr(input logic [7:0] addr);
    return addr & pmc_pkg::ADDR_MASK;
  endfunction : pmc_word_addr

  // Software runs only while the core is clocked, so only these modes may take commands.
  function automatic logic pmc_core_runs(input pmc_pkg::pmc_mode_t mode);
    return mode == pmc_pkg::PMC_FULL_ON || mode == pmc_pkg::PMC_ACTIVE;
  endfunction : pmc_core_runs

  pmc_pkg::pmc_state_t s_q;
  pmc_pkg::pmc_state_t s_d;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [31:0] wv;
    logic [31:0] pll_word;
    logic [31:0] reg_word;
    logic [7:0]  wa;
    logic        do_write;
    logic        rtc_hit;
    logic        pll_ok;
    logic [1:0]  cmd;
    logic [7:0]  ra;
    wv       = 32'h0000_0000;
    pll_word = 32'h0000_0000;
    reg_word = 32'h0000_0000;
    wa       = 8'h00;
    do_write = 1'b0;
    cmd      = pmc_pkg::CMD_FULL_ON;
    ra       = pmc_word_addr(s_axi_araddr);
    s_d      = s_q;

    // Pins go through two flip-flops before any logic reads them.
    s_d.rtc_s1  = rtc_wakeup;
    s_d.rtc_s2  = s_q.rtc_s1;
    s_d.wake_s1 = wakeup_event;
    s_d.wake_s2 = s_q.wake_s1;
    rtc_hit     = s_q.rtc_s2;
    pll_ok      = s_q.pll_enable;

    pll_word[pmc_pkg::PLL_BYPASS_BIT] = s_q.pll_bypass;
    pll_word[pmc_pkg::PLL_ENABLE_BIT] = s_q.pll_enable;
    reg_word[pmc_pkg::SW_HI:pmc_pkg::SW_LO]     = s_q.sw_field;
    reg_word[pmc_pkg::VSEL_HI:pmc_pkg::VSEL_LO] = s_q.vsel;
    reg_word[pmc_pkg::VREG_BYP_BIT]             = s_q.vreg_bypass;

    // Address and data are taken in either order and held until both are present.
    if (s_axi_awvalid && s_q.axi.awready) begin
      s_d.aw_seen     = 1'b1;
      s_d.aw_addr     = pmc_word_addr(s_axi_awaddr);
      s_d.axi.awready = 1'b0;
    end
    if (s_axi_wvalid && s_q.axi.wready) begin
      s_d.w_seen    = 1'b1;
      s_d.w_data    = s_axi_wdata;
      s_d.w_strb    = s_axi_wstrb;
      s_d.axi.wready = 1'b0;
    end
    if (s_q.aw_seen && s_q.w_seen && !s_q.axi.bvalid) begin
      do_write        = 1'b1;
      wa              = s_q.aw_addr;
      s_d.aw_seen     = 1'b0;
      s_d.w_seen      = 1'b0;
      s_d.axi.bvalid  = 1'b1;
      s_d.axi.bresp   = pmc_pkg::RESP_OKAY;
    end
    if (s_q.axi.bvalid && s_axi_bready) begin
      s_d.axi.bvalid  = 1'b0;
      s_d.axi.awready = 1'b1;
      s_d.axi.wready  = 1'b1;
    end

    if (do_write) begin
      if (wa == pmc_pkg::PLL_CTRL_OFF) begin
        wv = pmc_merge(pll_word, s_q.w_data, s_q.w_strb);
        s_d.pll_bypass = wv[pmc_pkg::PLL_BYPASS_BIT];
        // The PLL may only be switched off while active.
        if (s_q.mode == pmc_pkg::PMC_ACTIVE || wv[pmc_pkg::PLL_ENABLE_BIT]) begin
          s_d.pll_enable = wv[pmc_pkg::PLL_ENABLE_BIT];
        end
      end else if (wa == pmc_pkg::REG_CTRL_OFF) begin
        wv = pmc_merge(reg_word, s_q.w_data, s_q.w_strb);
        s_d.sw_field    = wv[pmc_pkg::SW_HI:pmc_pkg::SW_LO];
        s_d.vsel        = wv[pmc_pkg::VSEL_HI:pmc_pkg::VSEL_LO];
        s_d.vreg_bypass = wv[pmc_pkg::VREG_BYP_BIT];
        // The bus stays clocked in every mode, so a stray write must not be taken as an exit.
        if (wv[pmc_pkg::SW_HI:pmc_pkg::SW_LO] == pmc_pkg::SW_OFF) begin
          if (pmc_core_runs(s_q.mode)) begin
            s_d.mode = pmc_pkg::PMC_HIBERNATE;
          end else begin
            s_d.sw_field = s_q.sw_field;
          end
        end
      end else if (wa == pmc_pkg::MODE_CMD_OFF) begin
        if (s_q.w_strb[0]) begin
          cmd = s_q.w_data[pmc_pkg::CMD_HI:pmc_pkg::CMD_LO];
          s_d.refused = 1'b0;
          if (pmc_core_runs(s_q.mode)) begin
            case (cmd)
              pmc_pkg::CMD_FULL_ON: begin
                if (pll_ok) begin
                  s_d.mode       = pmc_pkg::PMC_FULL_ON;
                  s_d.pll_bypass = 1'b0;
                end else begin
                  s_d.refused = 1'b1;
                end
              end
              pmc_pkg::CMD_ACTIVE: begin
                s_d.mode       = pmc_pkg::PMC_ACTIVE;
                s_d.pll_bypass = 1'b1;
              end
              pmc_pkg::CMD_SLEEP: begin
                if (pll_ok) begin
                  s_d.mode = pmc_pkg::PMC_SLEEP;
                end else begin
                  s_d.refused = 1'b1;
                end
              end
              default: begin
                s_d.mode = pmc_pkg::PMC_DEEP_SLEEP;
              end
            endcase
          end else begin
            s_d.refused = 1'b1;
          end
        end
      end else begin
        s_d.axi.bresp = pmc_pkg::RESP_SLVERR;
      end
    end

    // Wakeups out of the low power modes.
    case (s_q.mode)
      pmc_pkg::PMC_SLEEP: begin
        if (s_q.wake_s2 || rtc_hit) begin
          s_d.mode = s_q.pll_bypass ? pmc_pkg::PMC_ACTIVE : pmc_pkg::PMC_FULL_ON;
        end
      end
      pmc_pkg::PMC_DEEP_SLEEP: begin
        if (rtc_hit) begin
          s_d.mode       = pmc_pkg::PMC_ACTIVE;
          s_d.pll_bypass = 1'b1;
        end
      end
      pmc_pkg::PMC_HIBERNATE: begin
        // Only the RTC reaches this domain; the reset pin restarts via aresetn.
        if (rtc_hit) begin
          // Waking from hibernate is a cold start, so the PLL returns to its power-up setting.
          s_d.mode       = pmc_pkg::PMC_FULL_ON;
          s_d.sw_field   = pmc_pkg::SW_RESET;
          s_d.pll_enable = 1'b1;
          s_d.pll_bypass = 1'b0;
        end
      end
      default: begin
      end
    endcase

    // Reads.
    if (s_axi_arvalid && s_q.axi.arready) begin
      s_d.axi.arready = 1'b0;
      s_d.axi.rvalid  = 1'b1;
      s_d.axi.rresp   = pmc_pkg::RESP_OKAY;
      s_d.axi.rdata   = 32'h0000_0000;
      if (ra == pmc_pkg::PLL_CTRL_OFF) begin
        s_d.axi.rdata = pll_word;
      end else if (ra == pmc_pkg::REG_CTRL_OFF) begin
        s_d.axi.rdata = reg_word;
      end else if (ra == pmc_pkg::MODE_CMD_OFF) begin
        s_d.axi.rdata = 32'h0000_0000;
      end else if (ra == pmc_pkg::STATUS_OFF) begin
        s_d.axi.rdata = {28'h0000000, s_q.refused, s_q.mode};
      end else begin
        s_d.axi.rresp = pmc_pkg::RESP_SLVERR;
      end
    end
    if (s_q.axi.rvalid && s_axi_rready) begin
      s_d.axi.rvalid  = 1'b0;
      s_d.axi.arready = 1'b1;
    end

    // Power outputs follow the next mode so they change with it.
    s_d.pwr.pll_en             = s_d.pll_enable && s_d.mode != pmc_pkg::PMC_HIBERNATE;
    s_d.pwr.pll_bypass         = s_d.pll_bypass || s_d.mode == pmc_pkg::PMC_ACTIVE;
    s_d.pwr.core_clk_en        = pmc_core_runs(s_d.mode);
    s_d.pwr.sys_clk_en         = s_d.pwr.core_clk_en || s_d.mode == pmc_pkg::PMC_SLEEP;
    s_d.pwr.dma_l1_allow       = s_d.pwr.core_clk_en;
    s_d.pwr.async_access_allow = s_d.pwr.sys_clk_en;
    s_d.pwr.regulator_on       = s_d.mode != pmc_pkg::PMC_HIBERNATE && !s_d.vreg_bypass;
    s_d.pwr.regulator_bypass   = s_d.vreg_bypass;
    s_d.pwr.vsel               = s_d.vsel;
    s_d.pwr.pins_hiz           = s_d.mode == pmc_pkg::PMC_HIBERNATE;
    s_d.pwr.boot_start         = s_q.mode == pmc_pkg::PMC_HIBERNATE && s_d.mode == pmc_pkg::PMC_FULL_ON;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q                  <= '0;
      s_q.mode             <= pmc_pkg::PMC_FULL_ON;
      s_q.pll_enable       <= 1'b1;
      s_q.pll_bypass       <= 1'b0;
      s_q.sw_field         <= pmc_pkg::SW_RESET;
      s_q.vsel             <= pmc_pkg::VSEL_RESET;
      s_q.axi.awready      <= 1'b1;
      s_q.axi.wready       <= 1'b1;
      s_q.axi.arready      <= 1'b1;
      s_q.pwr.pll_en       <= 1'b1;
      s_q.pwr.core_clk_en  <= 1'b1;
      s_q.pwr.sys_clk_en   <= 1'b1;
      s_q.pwr.dma_l1_allow <= 1'b1;
      s_q.pwr.async_access_allow <= 1'b1;
      s_q.pwr.regulator_on <= 1'b1;
      s_q.pwr.vsel         <= pmc_pkg::VSEL_RESET;
      s_q.pwr.pll_bypass   <= 1'b0;
      s_q.pwr.pins_hiz     <= 1'b0;
      s_q.pwr.boot_start   <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Port outputs
  // ----------------------------------------------------------------
  assign s_axi_awready = s_q.axi.awready;
  assign s_axi_wready  = s_q.axi.wready;
  assign s_axi_bvalid  = s_q.axi.bvalid;
  assign s_axi_bresp   = s_q.axi.bresp;
  assign s_axi_arready = s_q.axi.arready;
  assign s_axi_rvalid  = s_q.axi.rvalid;
  assign s_axi_rdata   = s_q.axi.rdata;
  assign s_axi_rresp   = s_q.axi.rresp;
  assign pwr           = s_q.pwr;

endmodule : pmc_power_mode_controller

// [pmc_checker.sv]
// Concurrent checks on the ports of the power mode controller.
module pmc_checker (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Register bus
  input wire logic                    s_axi_awvalid,
  input wire logic                    s_axi_awready,
  input wire logic                    s_axi_wvalid,
  input wire logic                    s_axi_wready,
  input wire logic                    s_axi_bvalid,
  input wire logic                    s_axi_arvalid,
  input wire logic                    s_axi_arready,
  input wire logic                    s_axi_rvalid,
  // Power controls
  input wire pmc_pkg::pmc_power_out_t pwr
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_full_on: assert property ($rose(aresetn) |-> pwr.pll_en && !pwr.pll_bypass && pwr.core_clk_en)
    else $error("full-on settings missing after reset");
  a_dma_with_core: assert property (pwr.dma_l1_allow == pwr.core_clk_en)
    else $error("level-one DMA permission does not follow the core clock");
  a_async_with_sys: assert property (pwr.async_access_allow == pwr.sys_clk_en)
    else $error("asynchronous access permission does not follow the system clock");
  a_sleep_pll_on: assert property (!pwr.core_clk_en && pwr.sys_clk_en |-> pwr.pll_en)
    else $error("PLL stopped while only the core clock is off");
  a_deep_core_off: assert property (!pwr.sys_clk_en |-> !pwr.core_clk_en && !pwr.dma_l1_allow)
    else $error("core still clocked with the system clock stopped");
  a_hib_supply_off: assert property (pwr.pins_hiz |-> !pwr.regulator_on && !pwr.sys_clk_en)
    else $error("pins floated while supply or clocks are on");
  a_boot_one_cycle: assert property (pwr.boot_start |=> !pwr.boot_start)
    else $error("boot start longer than one cycle");
  a_boot_on_wake: assert property ($fell(pwr.pins_hiz) |-> pwr.boot_start && pwr.regulator_on)
    else $error("hibernate left without boot start");
  a_pll_off_active: assert property ($fell(pwr.pll_en) && pwr.sys_clk_en |-> pwr.pll_bypass)
    else $error("PLL disabled outside the bypassed mode");
  a_deep_to_active: assert property ($rose(pwr.sys_clk_en) && !$past(pwr.pins_hiz) |-> pwr.pll_bypass)
    else $error("deep sleep not left towards the bypassed mode");
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
    else $error("read response late");
endmodule : pmc_checker

bind pmc_power_mode_controller pmc_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .pwr);

// [tb_power_mode_controller.sv]
// Self-checking testbench for the power mode controller.
module tb_power_mode_controller;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [7:0]  a;
    logic [31:0] d;
    logic [2:0]  m;
    logic [2:0]  c;
  } pmc_row_t;
  logic                    aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, arvalid, arready, rvalid;
  logic                    rtc, ev, boot_seen;
  logic [7:0]              awaddr, araddr;
  logic [31:0]             wdata, rdata, rd;
  logic [1:0]              bresp, rresp, resp;
  pmc_pkg::pmc_power_out_t pwr;
  int                      error_cnt = 0;
  int                      checks_done = 0;
  int                      cyc = 0;
  // Rows: command, expected mode, expected {core, sys, bypass}.
  pmc_row_t rows[5] = '{'{8'h08, 32'h0, 3'h0, 3'h6}, '{8'h08, 32'h1, 3'h1, 3'h7}, '{8'h08, 32'h0, 3'h0, 3'h6},
                        '{8'h08, 32'h2, 3'h2, 3'h2}, '{8'h08, 32'h1, 3'h2, 3'h2}};

  // Responses are always accepted at once, so bready and rready stay high.
  pmc_power_mode_controller dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_awaddr(awaddr), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
    .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_bresp(bresp), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_araddr(araddr), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .rtc_wakeup(rtc), .wakeup_event(ev), .pwr(pwr));

  // ----------------------------------------------------------------
  // Bus tasks and compares
  // ----------------------------------------------------------------
  task automatic summarize();
    $display("errors %0d checks %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : summarize

  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    checks_done++;
    if (g !== e) begin
      error_cnt++;
      $display("MISMATCH t=%0t got %h expected %h", $time, g, e);
    end
  endtask : chk_val

  task automatic chk_resp(input logic [1:0] g, input logic [1:0] e);
    chk_val({30'h0, g}, {30'h0, e});
  endtask : chk_resp

  task automatic axi_write(input logic [7:0] a, input logic [31:0] v);
    logic aw_done, w_done;
    aw_done = 1'b0;
    w_done = 1'b0;
    awvalid <= 1'b1;
    awaddr <= a;
    wvalid <= 1'b1;
    wdata <= v;
    while (!(aw_done && w_done)) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      aw_done = aw_done | awready;
      w_done = w_done | wready;
    end
    do @(posedge aclk); while (!bvalid);
    resp = bresp;
  endtask : axi_write

  task automatic axi_read(input logic [7:0] a);
    arvalid <= 1'b1;
    araddr <= a;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    rd = rdata;
    resp = rresp;
  endtask : axi_read

  task automatic st(input logic [2:0] m);
    axi_read(8'h0c);
    chk_val({29'h0, rd[2:0]}, {29'h0, m});
  endtask : st

  // Pin inputs pass a two-flop synchroniser, so six cycles cover the change.
  task automatic pin(input logic rt, input logic e);
    rtc <= rt;
    ev <= e;
    repeat (6) begin
      @(posedge aclk);
      boot_seen = boot_seen | pwr.boot_start;
    end
    rtc <= 1'b0;
    ev <= 1'b0;
    @(posedge aclk);
  endtask : pin

  // ----------------------------------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------------------------------
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      error_cnt++;
      summarize();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, arvalid, rtc, ev} <= 6'h00;
    {awaddr, araddr, wdata} <= 48'h0000_0000_0000;
    boot_seen = 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    chk_val({27'h0, pwr.pll_en, pwr.pll_bypass, pwr.core_clk_en, pwr.regulator_on, pwr.pins_hiz}, 32'h16);
    axi_read(8'h00);
    chk_val(rd, 32'h2);
    axi_read(8'h04);
    chk_val(rd, 32'h83);
    foreach (rows[i]) begin
      axi_write(rows[i].a, rows[i].d);
      st(rows[i].m);
      chk_val({29'h0, pwr.core_clk_en, pwr.sys_clk_en, pwr.pll_bypass}, {29'h0, rows[i].c});
    end
    pin(1'b0, 1'b1);
    st(3'h0);
    axi_write(8'h08, 32'h1);
    axi_write(8'h08, 32'h2);
    pin(1'b1, 1'b0);
    st(3'h1);
    axi_write(8'h00, 32'h1);
    chk_val({31'h0, pwr.pll_en}, 32'h0);
    axi_write(8'h08, 32'h0);
    axi_read(8'h0c);
    chk_val({28'h0, rd[3:0]}, 32'h9);
    axi_write(8'h08, 32'h2);
    st(3'h1);
    axi_write(8'h00, 32'h3);
    axi_write(8'h08, 32'h3);
    chk_val({28'h0, pwr.core_clk_en, pwr.sys_clk_en, pwr.dma_l1_allow, pwr.async_access_allow}, 32'h0);
    pin(1'b0, 1'b1);
    st(3'h3);
    pin(1'b1, 1'b0);
    st(3'h1);
    axi_write(8'h04, 32'h153);
    chk_resp(resp, pmc_pkg::RESP_OKAY);
    chk_val({27'h0, pwr.vsel, pwr.regulator_bypass}, 32'hb);
    axi_read(8'h04);
    chk_val(rd, 32'h153);
    axi_write(8'h04, 32'h83);
    axi_write(8'h10, 32'h0);
    chk_resp(resp, pmc_pkg::RESP_SLVERR);
    axi_read(8'h10);
    chk_resp(resp, pmc_pkg::RESP_SLVERR);
    axi_read(8'h00);
    chk_val(rd, 32'h3);
    boot_seen = 1'b0;
    axi_write(8'h04, 32'h80);
    chk_val({28'h0, pwr.regulator_on, pwr.pins_hiz, pwr.core_clk_en, pwr.sys_clk_en}, 32'h4);
    pin(1'b1, 1'b0);
    chk_val({28'h0, boot_seen, pwr.regulator_on, pwr.pll_en, pwr.pll_bypass}, 32'he);
    st(3'h0);
    axi_write(8'h08, 32'h3);
    axi_write(8'h04, 32'h80);
    st(3'h3);
    axi_read(8'h04);
    chk_val(rd, 32'h83);
    aresetn <= 1'b0;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    st(3'h0);
    summarize();
  end
endmodule : tb_power_mode_controller
